// ---- include/alarm_pkg.sv ----
// Constants and carrier types for the converter alarm status and mask block.
// Assumes a byte-wide configuration port with address, write and read strobes.
//
// Function
// R1: lane FIFO overflow or underflow sets status bit 5.
// R2: writing one clears a status flag; writing zero leaves it.
// R3: serializer PLL out of lock sets status bit 4.
// R4: 8B/10B: link enabled but not in user-data state sets bit 3.
// R5: 64B/66B: link start or any realignment sets bit 3.
// R6: SYSREF realignment of internal clocks sets status bit 2.
// R7: divider phase mismatch between channel pairs sets status bit 0.
// R8: after power-on or soft reset every status flag reads one.
// R9: with link disabled only the divider mismatch flag is meaningful.
// R10: software should clear all flags after enabling the link.
// R11: mask bits 5,4,3,2,0 exclude flags from summary; reset to one.
// R12: software writes reserved mask bits as zero at 7:6, one at 1.
// R13: per-lane FIFO alarm register, eight bits, resets to all ones.
// R14: software reads per-lane register after seeing the lane FIFO flag.
// R15: summary alarm is one when any unmasked flag is set; may drive pin.
// R16: lane i FIFO fault sets bit i; writing one clears it.
// R17: writing one to lane FIFO flag clears all per-lane bits.
// R18: flags are sticky and set again at once if the cause persists.
package alarm_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [11:0] SUMMARY_ADDR    = 12'h2C0;
   localparam logic [11:0] FLAG_ADDR       = 12'h2C1;
   localparam logic [11:0] SUPPRESS_ADDR   = 12'h2C2;
   localparam logic [11:0] LANE_ERR_ADDR   = 12'h2C4;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int BIT_FIFO    = 5;
   localparam int BIT_SPLL    = 4;
   localparam int BIT_LINK    = 3;
   localparam int BIT_REALIGN = 2;
   localparam int BIT_CLK     = 0;
   localparam logic [7:0] FLAG_RESET     = 8'h3F;
   localparam logic [7:0] SUPPRESS_RESET = 8'h3F;
   localparam logic [7:0] LANE_RESET     = 8'hFF;
   localparam logic [7:0] FLAG_IMPL      = 8'h3D;
   localparam logic [7:0] SUPPRESS_IMPL  = 8'h3F;
   localparam int NUM_LANES = 8;

   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } cfg_req_type;

   typedef struct packed {
      logic       serial_link_enable;
      logic       enc_64b66b;
      logic       user_data_state;
      logic       link_start;
      logic       realign_event;
      logic       spll_locked;
      logic       sysref_realign;
      logic       divider_mismatch;
      logic [7:0] lane_fifo_fault;
   } alarm_src_type;

endpackage

// ---- design/alarm_status_mask.sv ----
// Alarm flag collection, mask and summary for the converter link.
// Assumes all cause inputs come from logic on i_ref_clk; soft reset drives i_rst.
module alarm_status_mask
   import alarm_pkg::*;
#(
   parameter int LANES = alarm_pkg::NUM_LANES
)(
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_rst,
   input  wire alarm_pkg::cfg_req_type i_cfg,
   input  wire alarm_pkg::alarm_src_type i_src,
   output logic [7:0]                  o_rdata,
   output logic                        o_rvalid,
   output logic                        o_status_output_pin
);
   import alarm_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] alarm_flag_bits_r,      alarm_flag_bits_nxt;
   logic [7:0] alarm_suppress_bits_r,  alarm_suppress_bits_nxt;
   logic [7:0] lane_fifo_error_bits_r, lane_fifo_error_bits_nxt;
   logic [7:0] rdata_r,                rdata_nxt;
   logic       rvalid_r,               rvalid_nxt;
   logic       summary_r,              summary_nxt;
   logic [7:0] cause;
   logic [7:0] flag_clr;
   logic [7:0] lane_clr;
   logic [7:0] lane_set;
   logic       link_cause;

   // ----------------------------------------
   // causes
   // ----------------------------------------
   always_comb
   begin
      lane_set = '0;
      lane_set[LANES-1:0] = i_src.lane_fifo_fault[LANES-1:0];          // R16
      // flags other than divider mismatch carry no meaning with link off
      if (i_src.enc_64b66b)
         link_cause = i_src.link_start | i_src.realign_event;         // R5
      else
         link_cause = ~i_src.user_data_state;                         // R4
      cause               = '0;
      cause[BIT_FIFO]     = |lane_set & i_src.serial_link_enable;       // R1 R9
      cause[BIT_SPLL]     = ~i_src.spll_locked & i_src.serial_link_enable; // R3 R9
      cause[BIT_LINK]     = link_cause & i_src.serial_link_enable;      // R4 R9
      cause[BIT_REALIGN]  = i_src.sysref_realign & i_src.serial_link_enable; // R6 R9
      cause[BIT_CLK]      = i_src.divider_mismatch;                     // R7
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_comb
   begin
      flag_clr = '0;
      lane_clr = '0;
      alarm_suppress_bits_nxt = alarm_suppress_bits_r;
      if (i_cfg.wr && i_cfg.addr == FLAG_ADDR)
      begin
         flag_clr = i_cfg.wdata & FLAG_IMPL;                             // R2
         if (i_cfg.wdata[BIT_FIFO])
            lane_clr = '1;                                              // R17
      end
      else if (i_cfg.wr && i_cfg.addr == SUPPRESS_ADDR)
         alarm_suppress_bits_nxt = i_cfg.wdata;                         // R11
      else if (i_cfg.wr && i_cfg.addr == LANE_ERR_ADDR)
         lane_clr = i_cfg.wdata;                                        // R16
      // set wins over clear; sticky until cleared
      alarm_flag_bits_nxt =
         (((alarm_flag_bits_r & ~flag_clr) | cause) & FLAG_IMPL)
         | (FLAG_RESET & ~FLAG_IMPL);                                   // R18
      lane_fifo_error_bits_nxt =
         (lane_fifo_error_bits_r & ~lane_clr) | lane_set;               // R18
   end

   // ----------------------------------------
   // read and summary
   // ----------------------------------------
   always_comb
   begin
      rvalid_nxt = i_cfg.rd;
      rdata_nxt  = '0;
      if (i_cfg.addr == SUMMARY_ADDR)
         rdata_nxt = {7'h00, summary_r};
      else if (i_cfg.addr == FLAG_ADDR)
         rdata_nxt = alarm_flag_bits_r;
      else if (i_cfg.addr == SUPPRESS_ADDR)
         rdata_nxt = alarm_suppress_bits_r;
      else if (i_cfg.addr == LANE_ERR_ADDR)
         rdata_nxt = lane_fifo_error_bits_r;                            // R13
      if (!i_cfg.rd)
         rdata_nxt = '0;
      summary_nxt = |(alarm_flag_bits_r & ~alarm_suppress_bits_r & SUPPRESS_IMPL
                      & FLAG_IMPL);                                     // R15
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         alarm_flag_bits_r      <= FLAG_RESET;                          // R8
         alarm_suppress_bits_r  <= SUPPRESS_RESET;                      // R11
         lane_fifo_error_bits_r <= LANE_RESET;                          // R13
         rdata_r                <= 8'h00;
         rvalid_r               <= 1'b0;
         summary_r              <= 1'b0;
      end
      else
      begin
         alarm_flag_bits_r      <= alarm_flag_bits_nxt;
         alarm_suppress_bits_r  <= alarm_suppress_bits_nxt;
         lane_fifo_error_bits_r <= lane_fifo_error_bits_nxt;
         rdata_r                <= rdata_nxt;
         rvalid_r               <= rvalid_nxt;
         summary_r              <= summary_nxt;
      end
   end

   assign o_rdata             = rdata_r;
   assign o_rvalid            = rvalid_r;
   assign o_status_output_pin = summary_r;                             // R15

endmodule

// ---- sim/alarm_status_mask_props.sv ----
// Checker for the alarm status and mask block.
// Assumes binding to the ports of alarm_status_mask.
module alarm_status_mask_props
   import alarm_pkg::*;
#(
   parameter int LANES = 8
)(
   input wire logic                     i_ref_clk,
   input wire logic                     i_rst,
   input wire alarm_pkg::cfg_req_type   i_cfg,
   input wire alarm_pkg::alarm_src_type i_src,
   input wire logic [7:0]               o_rdata,
   input wire logic                     o_rvalid,
   input wire logic                     o_status_output_pin
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   wire en = i_src.serial_link_enable;
   wire link_bad = en && !i_src.enc_64b66b && !i_src.user_data_state;
   sequence flag_rd;
      i_cfg.rd && i_cfg.addr == FLAG_ADDR;
   endsequence
   chk_read_answer: assert property (i_cfg.rd |=> o_rvalid)
      else $error("read not answered");
   chk_fifo_set: assert property ((en && |i_src.lane_fifo_fault) ##1 flag_rd |=> o_rdata[5])
      else $error("fifo flag not set");
   chk_pll_set: assert property ((en && !i_src.spll_locked) ##1 flag_rd |=> o_rdata[4])
      else $error("pll flag not set");
   chk_link_set: assert property (link_bad ##1 flag_rd |=> o_rdata[3])
      else $error("link flag not set");
   chk_realign_set: assert property ((en && i_src.sysref_realign) ##1 flag_rd |=> o_rdata[2])
      else $error("realign flag not set");
   chk_mismatch_set: assert property (i_src.divider_mismatch ##1 flag_rd |=> o_rdata[0])
      else $error("mismatch flag not set");
   chk_reserved_read: assert property (flag_rd |=> o_rdata[7:6] == 2'h0 && o_rdata[1])
      else $error("reserved flag bits wrong");
   chk_summary_pin: assert property (i_cfg.rd && i_cfg.addr == SUMMARY_ADDR
      |=> o_rdata == {7'h00, $past(o_status_output_pin)}) else $error("summary differs from pin");
endmodule
bind alarm_status_mask alarm_status_mask_props #(.LANES(LANES)) u_props (.i_ref_clk, .i_rst,
   .i_cfg, .i_src, .o_rdata, .o_rvalid, .o_status_output_pin);

// ---- sim/alarm_status_mask_test.sv ----
// Self-checking bench for the alarm status and mask block.
// Drives config port and causes at the falling edge; checker is bound.
module alarm_status_mask_test;
   import alarm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // link on, pll locked, in user data
   localparam alarm_src_type IDLE = 16'hA400;
   logic          i_ref_clk = 0;
   logic          i_rst = 1;
   cfg_req_type   i_cfg = '0;
   alarm_src_type i_src = IDLE;
   logic [7:0]    o_rdata, lanes;
   logic          o_rvalid, o_status_output_pin;
   logic [7:0]    exp_q[$];
   int            n_errors = 0, tests_run = 0;
   int            bits[7] = '{5, 4, 3, 2, 0, 3, 3};
   always #20 i_ref_clk = ~i_ref_clk;
   alarm_status_mask u_dut (.i_ref_clk, .i_rst, .i_cfg, .i_src, .o_rdata, .o_rvalid,
      .o_status_output_pin);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
      if (!w)
         exp_q.push_back(d);
      i_cfg = {w, !w, a, d};
      @(negedge i_ref_clk);
      i_cfg = '0;
      @(negedge i_ref_clk);
   endtask
   task automatic conclude();
      $display("%0d mismatches in %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(negedge i_ref_clk)
      if (o_rvalid === 1'b1)
         check(o_rdata, exp_q.pop_front());
   initial
   begin
      void'($urandom(27));
      repeat (2) @(negedge i_ref_clk);
      i_rst = 0;
      acc(0, FLAG_ADDR, 8'h3F);
      acc(0, SUPPRESS_ADDR, 8'h3F);
      acc(0, LANE_ERR_ADDR, 8'hFF);
      acc(0, SUMMARY_ADDR, 8'h00);
      acc(0, 12'h2C3, 8'h00);
      acc(1, FLAG_ADDR, 8'hFF);
      acc(0, FLAG_ADDR, 8'h02);
      acc(0, LANE_ERR_ADDR, 8'h00);
      for (int k = 0; k < 7; k++)
      begin
         lanes = 8'($urandom) | 8'h01;
         case (k)
            0: i_src.lane_fifo_fault = lanes;
            1: i_src.spll_locked = 1'b0;
            2: i_src.user_data_state = 1'b0;
            3: i_src.sysref_realign = 1'b1;
            4: i_src.divider_mismatch = 1'b1;
            5: {i_src.enc_64b66b, i_src.link_start} = 2'h3;
            default: {i_src.enc_64b66b, i_src.realign_event} = 2'h3;
         endcase
         acc(1, FLAG_ADDR, 8'h00);
         i_src = IDLE;
         acc(0, FLAG_ADDR, 8'h02 | (8'h01 << bits[k]));
         if (k == 0)
         begin
            acc(0, LANE_ERR_ADDR, lanes);
            acc(1, LANE_ERR_ADDR, lanes & 8'h0F);
            acc(0, LANE_ERR_ADDR, lanes & 8'hF0);
         end
         acc(1, FLAG_ADDR, 8'hFF);
      end
      i_src.divider_mismatch = 1'b1;
      acc(1, FLAG_ADDR, 8'hFF);
      acc(0, FLAG_ADDR, 8'h03);
      acc(1, SUPPRESS_ADDR, 8'h3E);
      acc(0, SUPPRESS_ADDR, 8'h3E);
      acc(0, SUMMARY_ADDR, 8'h01);
      check({7'h00, o_status_output_pin}, 8'h01);
      i_src = IDLE;
      acc(1, FLAG_ADDR, 8'h01);
      acc(0, SUMMARY_ADDR, 8'h00);
      if (exp_q.size() != 0)
         n_errors++;
      conclude();
   end
endmodule
